// file: rtl/pwpb_bridge.sv
// High-speed bus to peripheral bus bridge with its write-protect guard
`include "pwpb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pwpb_bridge #(
    parameter int          SLOT_W     = `PWPB_SLOT_W,
    parameter logic        GCLK_RESET = `PWPB_GCLK_RESET_B0,
    parameter logic [31:0] PROT_RESET = `PWPB_CORE_RESET,
    parameter logic [31:0] PROT_MASK  = `PWPB_CORE_MASK
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // High-speed bus slave port
    input  wire logic                    hsel_i,
    input  wire logic [31:0]             haddr_i,
    input  wire logic [1:0]              htrans_i,
    input  wire logic                    hwrite_i,
    input  wire logic [2:0]              hsize_i,
    input  wire logic [3:0]              hprot_i,
    input  wire logic [3:0]              hmaster_i,
    input  wire logic                    hready_i,
    input  wire logic [31:0]             hwdata_i,
    output logic      [31:0]             hrdata_o,
    output logic                         hreadyout_o,
    output logic                         hresp_o,
    // Peripheral bus master port
    output logic      [(1<<SLOT_W)-1:0]  psel_o,
    output logic                         penable_o,
    output logic      [31:0]             paddr_o,
    output logic                         pwrite_o,
    output logic      [31:0]             pwdata_o,
    output logic      [3:0]              pstrb_o,
    output logic      [2:0]              pprot_o,
    input  wire logic [31:0]             prdata_i,
    input  wire logic                    pready_i,
    input  wire logic                    pslverr_i,
    // Guard clock control from the power manager, and protection state out
    input  wire logic                    pm_gclk_enable_i,
    input  wire logic                    pm_gclk_disable_i,
    output logic                         guard_clk_en_o,
    output logic      [31:0]             prot_state_o
);
    localparam int NSLOT = 1 << SLOT_W;

    pwpb_pkg::pwpb_state_t state_reg;
    pwpb_pkg::pwpb_state_t state_next;

    logic [31:0] addr_reg;
    logic        write_reg;
    logic [3:0]  strb_reg;
    logic [2:0]  pprot_reg;
    logic        dbg_reg;
    logic [31:0] wdata_reg;
    logic [31:0] rdata_reg;
    logic        gclk_en_reg;

    pwpb_guard_if gif ();

    // One guard per bridge, bit n guarding slot n [R6]
    pwpb_guard #(
        .PROT_RESET (PROT_RESET),
        .PROT_MASK  (PROT_MASK)
    ) u_guard (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .gif   (gif)
    );

    // Address phase acceptance
    wire logic can_take  = (state_reg == pwpb_pkg::BR_IDLE)
                         | (state_reg == pwpb_pkg::BR_RESP)
                         | (state_reg == pwpb_pkg::BR_ERR2);
    wire logic addr_take = hsel_i & hready_i & htrans_i[1] & can_take; // [R1]
    wire logic [3:0] take_strb = pwpb_pkg::pwpb_lane_strb(hsize_i, haddr_i[1:0]);

    // Target decode from the captured address
    wire logic [SLOT_W-1:0] slot     = addr_reg[`PWPB_SLOT_LSB +: SLOT_W];
    wire logic              to_guard = (slot == `PWPB_GUARD_SLOT);
    wire logic              in_acc   = (state_reg == pwpb_pkg::BR_ACCESS);
    wire logic              ext_acc  = in_acc & ~to_guard;

    // Protection is held in flops that need no guard clock, so it keeps
    // acting in every sleep state as long as the bridge itself is clocked [R8]
    wire logic slot_prot = gif.prot[slot];
    wire logic blocked   = write_reg & slot_prot & ~dbg_reg & ~to_guard; // [R9] [R14]

    // Completion and error of the merged access cycle
    wire logic acc_done = to_guard ? 1'b1 : pready_i; // [R2]
    wire logic acc_err  = to_guard ? gif.err : pslverr_i; // [R2] [R21]
    wire logic [31:0] acc_data = (to_guard ? gif.rdata : prdata_i)
                               & pwpb_pkg::pwpb_strb_mask(strb_reg); // [R4]

    // Guard register port
    assign gif.sel    = in_acc & to_guard;
    assign gif.write  = write_reg;
    assign gif.ofs    = addr_reg[`PWPB_SLOT_LSB-1:0];
    assign gif.wdata  = wdata_reg;
    assign gif.strb   = strb_reg;
    assign gif.clk_en = gclk_en_reg;

    // Select and enable rise together: no separate setup cycle [R3]
    assign psel_o    = ext_acc ? ({{(NSLOT-1){1'b0}}, 1'b1} << slot) : {NSLOT{1'b0}};
    assign penable_o = ext_acc; // [R3]
    assign paddr_o   = addr_reg;
    assign pwrite_o  = write_reg;
    assign pwdata_o  = wdata_reg;
    assign pstrb_o   = strb_reg; // [R4]
    assign pprot_o   = pprot_reg; // [R2]

    // Bus answer
    assign hreadyout_o    = can_take;
    assign hresp_o        = ((state_reg == pwpb_pkg::BR_ERR1) | (state_reg == pwpb_pkg::BR_ERR2))
                          ? `PWPB_HRESP_ERROR : `PWPB_HRESP_OKAY;
    assign hrdata_o       = rdata_reg;
    assign guard_clk_en_o = gclk_en_reg;
    assign prot_state_o   = gif.prot;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            pwpb_pkg::BR_IDLE,
            pwpb_pkg::BR_RESP,
            pwpb_pkg::BR_ERR2:
            begin
                state_next = addr_take ? pwpb_pkg::BR_LATCH : pwpb_pkg::BR_IDLE;
            end
            pwpb_pkg::BR_LATCH:
            begin
                // A blocked write never reaches the peripheral [R14]
                state_next = blocked ? pwpb_pkg::BR_ERR1 : pwpb_pkg::BR_ACCESS;
            end
            pwpb_pkg::BR_ACCESS:
            begin
                if (acc_done)
                begin
                    state_next = acc_err ? pwpb_pkg::BR_ERR1 : pwpb_pkg::BR_RESP; // [R21]
                end
            end
            pwpb_pkg::BR_ERR1:
            begin
                state_next = pwpb_pkg::BR_ERR2;
            end
            default:
            begin
                state_next = pwpb_pkg::BR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg <= pwpb_pkg::BR_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Address phase capture
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            addr_reg  <= 32'h0000_0000;
            write_reg <= 1'b0;
            strb_reg  <= 4'h0;
            pprot_reg <= 3'h0;
            dbg_reg   <= 1'b0;
        end
        else if (addr_take)
        begin
            addr_reg  <= haddr_i;
            write_reg <= hwrite_i;
            strb_reg  <= take_strb; // [R4]
            pprot_reg <= {~hprot_i[0], 1'b1, hprot_i[1]}; // [R2]
            dbg_reg   <= (hmaster_i == `PWPB_DEBUG_ID); // [R9]
        end
    end

    // Write data arrives in the bus data phase, one cycle after the address
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wdata_reg <= 32'h0000_0000;
        end
        else if (state_reg == pwpb_pkg::BR_LATCH)
        begin
            wdata_reg <= hwdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_reg <= 32'h0000_0000;
        end
        else if (in_acc && acc_done && !write_reg)
        begin
            rdata_reg <= acc_data; // [R1]
        end
    end

    // Enable wins when both requests land in the same cycle
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            gclk_en_reg <= GCLK_RESET; // [R7]
        end
        else if (pm_gclk_enable_i)
        begin
            gclk_en_reg <= 1'b1;
        end
        else if (pm_gclk_disable_i)
        begin
            gclk_en_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: rtl/pwpb_cfg.svh
// Constants for the peripheral write-protect bridge and its guard
// Overview of operation
// R1: Bridge is a high-speed bus slave turning each access into a peripheral transfer.
// R2: Peripheral side supports wait states, errors, protection signalling and byte strobes.
// R3: Address and data of a peripheral transfer are presented in one merged cycle.
// R4: Byte and half-word lane selection also applies to read transfers.
// R5: System must enable the bridge clock before any access is attempted.
// R6: One guard per bridge, one protection bit per attached peripheral.
// R7: Guard clock of bridges zero and one resets enabled, bridge two disabled.
// R8: Protection stays enforced in any sleep state while the clock runs.
// R9: Debugger writes bypass protection and always reach the peripheral.
// R10: Writing one to a clear-view bit clears that shared protection bit.
// R11: Writing one to a set-view bit sets that shared protection bit.
// R12: Writing zero to any protection bit leaves it unchanged.
// R13: Both views read back the same protection vector.
// R14: Non-debugger write to protected peripheral is dropped and answered with error.
// R15: Protecting a protected or unprotecting an unprotected peripheral gives an error.
// R16: Software must avoid concurrent protection changes or read state before changing.
// R17: Guard registers accept 8-, 16- and 32-bit accesses on any lane.
// R18: Core guard: bit 1 debug unit, 2 flash, 3 port, 6 trace; bit 1 resets one.
// R19: Peripheral guard: events bit 1, serial 2-7, timers 8-15, analog 16-19.
// R20: Set view sits at offset 0x04 with clear view layout and reset.
// R21: Guard errors return as peripheral slave error, forwarded as bus error.
`ifndef PWPB_CFG_SVH
`define PWPB_CFG_SVH

`define PWPB_SLOT_LSB       10
`define PWPB_SLOT_W         5
`define PWPB_GUARD_SLOT     5'h00
`define PWPB_OFS_CLR        10'h000
`define PWPB_OFS_SET        10'h004 // [R20]
`define PWPB_DEBUG_ID       4'h1
`define PWPB_CORE_RESET     32'h0000_0002 // [R18]
`define PWPB_CORE_MASK      32'h0000_004E // [R18]
`define PWPB_PERI_RESET     32'h0080_0000 // [R19]
`define PWPB_PERI_MASK      32'h000F_FFFE // [R19]
`define PWPB_GCLK_RESET_B0  1'b1 // [R7]
`define PWPB_GCLK_RESET_B1  1'b1 // [R7]
`define PWPB_GCLK_RESET_B2  1'b0 // [R7]
`define PWPB_HRESP_OKAY     1'b0
`define PWPB_HRESP_ERROR    1'b1

`endif

// file: rtl/pwpb_pkg.sv
// Types and shared helpers for the peripheral write-protect bridge
package pwpb_pkg;

    typedef enum logic [2:0]
    {
        BR_IDLE   = 3'h0,
        BR_LATCH  = 3'h1,
        BR_ACCESS = 3'h2,
        BR_RESP   = 3'h3,
        BR_ERR1   = 3'h4,
        BR_ERR2   = 3'h5
    } pwpb_state_t;

    // Byte lanes touched by a transfer of the given size at the given address
    function automatic logic [3:0] pwpb_lane_strb(input logic [2:0] size, input logic [1:0] addr);
        logic [3:0] strb;
        strb = 4'hF;
        case (size)
            3'h0:    strb = 4'h1 << addr;
            3'h1:    strb = addr[1] ? 4'hC : 4'h3;
            default: strb = 4'hF;
        endcase
        return strb;
    endfunction

    function automatic logic [31:0] pwpb_strb_mask(input logic [3:0] strb);
        return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

endpackage

// file: rtl/pwpb_guard_if.sv
// Connection between the bridge and its write-protect guard
`include "pwpb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
interface pwpb_guard_if;
    logic                     sel;
    logic                     write;
    logic [`PWPB_SLOT_LSB-1:0] ofs;
    logic [31:0]              wdata;
    logic [3:0]               strb;
    logic                     clk_en;
    logic [31:0]              rdata;
    logic                     err;
    logic [31:0]              prot;

    modport guard  (input sel, write, ofs, wdata, strb, clk_en, output rdata, err, prot);
    modport bridge (output sel, write, ofs, wdata, strb, clk_en, input rdata, err, prot);
endinterface
`default_nettype wire

// file: rtl/pwpb_guard.sv
// Write-protect guard: shared protection vector with set and clear views
`include "pwpb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pwpb_guard #(
    parameter logic [31:0] PROT_RESET = `PWPB_CORE_RESET,
    parameter logic [31:0] PROT_MASK  = `PWPB_CORE_MASK
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    pwpb_guard_if.guard       gif
);
    logic [31:0] prot_reg;
    logic [31:0] prot_next;

    // Only bytes on active lanes count, so any access width works [R17]
    wire logic [31:0] lane_mask = pwpb_pkg::pwpb_strb_mask(gif.strb);
    wire logic [31:0] ones      = gif.wdata & lane_mask & PROT_MASK; // [R12]
    // Lane bits of the offset are dropped so byte and half-word accesses still hit [R17]
    wire logic [`PWPB_SLOT_LSB-1:0] word_ofs = {gif.ofs[`PWPB_SLOT_LSB-1:2], 2'h0};
    // A stopped guard clock makes the registers unreachable, not the protection
    wire logic        hit_clr   = gif.sel & gif.clk_en & (word_ofs == `PWPB_OFS_CLR);
    wire logic        hit_set   = gif.sel & gif.clk_en & (word_ofs == `PWPB_OFS_SET); // [R20]
    wire logic        wr_clr    = hit_clr & gif.write;
    wire logic        wr_set    = hit_set & gif.write;
    wire logic        dbl_clr   = wr_clr & (|(ones & ~prot_reg)); // [R15]
    wire logic        dbl_set   = wr_set & (|(ones & prot_reg)); // [R15]

    assign gif.err   = dbl_clr | dbl_set; // [R21]
    assign gif.rdata = (hit_clr | hit_set) ? prot_reg : 32'h0000_0000; // [R13]
    assign gif.prot  = prot_reg;

    // An erroneous double protect or unprotect changes nothing
    always_comb
    begin
        prot_next = prot_reg;
        if (wr_set && !dbl_set)
        begin
            prot_next = prot_reg | ones; // [R11]
        end
        else if (wr_clr && !dbl_clr)
        begin
            prot_next = prot_reg & ~ones; // [R10]
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            prot_reg <= PROT_RESET;
        end
        else
        begin
            prot_reg <= prot_next;
        end
    end
endmodule
`default_nettype wire

// file: tb/pwpb_bridge_asserts.sv
// Concurrent checks on the bridge top-level ports
`timescale 1ns/1ps
`default_nettype none
module pwpb_bridge_chk #(
    parameter logic [31:0] PROT_RESET = 32'h0000_0002,
    parameter logic [31:0] PROT_MASK  = 32'h0000_004E
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic [3:0]  hmaster_i,
    input wire logic        hready_i,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic [31:0] psel_o,
    input wire logic        penable_o,
    input wire logic [31:0] paddr_o,
    input wire logic        pwrite_o,
    input wire logic [31:0] pwdata_o,
    input wire logic [3:0]  pstrb_o,
    input wire logic        pready_i,
    input wire logic [31:0] prot_state_o
);
    wire       taken = hsel_i && hready_i && htrans_i[1] && hreadyout_o;
    wire [4:0] slot  = haddr_i[14:10];
    wire       ext_wr = taken && hwrite_i && (slot != 5'h00);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_err_two_cycle: assert property ($rose(hresp_o) |-> !hreadyout_o ##1 (hresp_o && hreadyout_o))
        else $error("error response not two cycles");
    a_merged_phase: assert property (|psel_o |-> penable_o)
        else $error("select without enable");
    a_one_select: assert property ($onehot0(psel_o) && !psel_o[0])
        else $error("bad peripheral select");
    a_wait_hold: assert property ((|psel_o && !pready_i) |=> psel_o == $past(psel_o) && $stable(paddr_o) && $stable(pwdata_o))
        else $error("transfer dropped during wait");
    a_block_write: assert property (ext_wr && hmaster_i != 4'h1 && prot_state_o[slot] |=> (psel_o == 32'h0)[*2] ##0 hresp_o)
        else $error("protected write not blocked");
    a_debug_pass: assert property (ext_wr && hmaster_i == 4'h1 |-> ##2 (|psel_o && pwrite_o))
        else $error("debugger write blocked");
    a_fixed_bits: assert property ((prot_state_o & ~PROT_MASK) == (PROT_RESET & ~PROT_MASK))
        else $error("fixed protection bit changed");
    a_read_lanes: assert property (|psel_o && !pwrite_o |-> pstrb_o != 4'h0)
        else $error("read without lanes");
    cover property (hresp_o && hreadyout_o);
    cover property (|psel_o && !pready_i);
    cover property ($changed(prot_state_o));
endmodule
bind pwpb_bridge pwpb_bridge_chk #(.PROT_RESET(PROT_RESET), .PROT_MASK(PROT_MASK)) chk_i (
    .clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hmaster_i, .hready_i,
    .hreadyout_o, .hresp_o, .psel_o, .penable_o, .paddr_o, .pwrite_o, .pwdata_o, .pstrb_o,
    .pready_i, .prot_state_o);
`default_nettype wire

// file: tb/pwpb_periph_model.sv
// Peripheral register blocks answering on the peripheral bus
`timescale 1ns/1ps
`default_nettype none
module pwpb_periph_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [31:0] psel_i,
    input  wire logic        penable_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    input  wire logic [3:0]  wait_i,
    input  wire logic        err_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o
);
    logic [31:0] mem [32];
    logic [3:0]  cnt;
    wire         act  = |psel_i && penable_i;
    wire  [4:0]  slot = paddr_i[14:10];
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt <= 4'h0;
            pready_o <= 1'h0;
            pslverr_o <= 1'h0;
            prdata_o <= 32'h0;
        end
        else if (pready_o)
        begin
            pready_o <= 1'h0;
            pslverr_o <= 1'h0;
            cnt <= 4'h0;
            prdata_o <= ~prdata_o; // Stale data must never look valid
        end
        else if (act && cnt < wait_i)
            cnt <= cnt + 4'h1;
        else if (act)
        begin
            pready_o <= 1'h1;
            pslverr_o <= err_i;
            prdata_o <= mem[slot];
            for (int b = 0; b < 4; b++)
                if (pwrite_i && !err_i && pstrb_i[b])
                    mem[slot][8*b +: 8] <= pwdata_i[8*b +: 8];
        end
    end
endmodule
`default_nettype wire

// file: tb/tb_pwpb_bridge.sv
// Register-access testbench for the peripheral write-protect bridge
`timescale 1ns/1ps
`default_nettype none
module tb_pwpb_bridge;
    logic clk_i = 1'h0, rst_i = 1'h1, hsel_i = 1'h0, hwrite_i = 1'h0, hready_i = 1'h1;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, paddr_o, pwdata_o, prdata_i;
    logic [31:0] psel_o, prot_state_o, rdat;
    logic [3:0] hprot_i = 4'h3, hmaster_i = 4'h0, pstrb_o, pwait = 4'h0;
    logic [2:0] hsize_i = 3'h2, pprot_o;
    logic [1:0] htrans_i = 2'h0;
    logic hreadyout_o, hresp_o, penable_o, pwrite_o, pready_i, pslverr_i, guard_clk_en_o;
    logic pm_gclk_enable_i = 1'h0, pm_gclk_disable_i = 1'h0, perr = 1'h0, rerr;
    logic [31:0] prot2;
    logic gclk2;
    int fail_count = 0, compares = 0;
    always #20 clk_i = ~clk_i;
    pwpb_bridge pwpb_bridge_i (.clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i, .hprot_i, .hmaster_i, .hready_i, .hwdata_i, .hrdata_o, .hreadyout_o,
        .hresp_o, .psel_o, .penable_o, .paddr_o, .pwrite_o, .pwdata_o, .pstrb_o, .pprot_o,
        .prdata_i, .pready_i, .pslverr_i, .pm_gclk_enable_i, .pm_gclk_disable_i,
        .guard_clk_en_o, .prot_state_o);
    pwpb_periph_model pwpb_periph_model_i (.clk_i, .rst_i, .psel_i(psel_o),
        .penable_i(penable_o), .paddr_i(paddr_o), .pwrite_i(pwrite_o), .pwdata_i(pwdata_o),
        .pstrb_i(pstrb_o), .wait_i(pwait), .err_i(perr), .prdata_o(prdata_i),
        .pready_o(pready_i), .pslverr_o(pslverr_i));
    // Third bridge with the peripheral-rich guard, only its reset state is looked at
    pwpb_bridge #(.GCLK_RESET(1'b0), .PROT_RESET(32'h0080_0000), .PROT_MASK(32'h000F_FFFE))
        pwpb_bridge_i2 (.clk_i, .rst_i, .hsel_i(1'h0), .haddr_i(32'h0), .htrans_i(2'h0),
        .hwrite_i(1'h0), .hsize_i(3'h2), .hprot_i(4'h3), .hmaster_i(4'h0), .hready_i(1'h1),
        .hwdata_i(32'h0), .hrdata_o(), .hreadyout_o(), .hresp_o(), .psel_o(), .penable_o(),
        .paddr_o(), .pwrite_o(), .pwdata_o(), .pstrb_o(), .pprot_o(), .prdata_i(32'h0),
        .pready_i(1'h0), .pslverr_i(1'h0), .pm_gclk_enable_i(1'h0), .pm_gclk_disable_i(1'h0),
        .guard_clk_en_o(gclk2), .prot_state_o(prot2));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Entered just after a rising edge; returns on the completing edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [2:0] sz,
                        input logic [3:0] m, input logic [31:0] wd);
        hsel_i <= 1'h1;
        haddr_i <= a;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        hsize_i <= sz;
        hmaster_i <= m;
        @(posedge clk_i);
        hsel_i <= 1'h0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do
            @(negedge clk_i);
        while (hreadyout_o !== 1'h1);
        rdat = hrdata_o;
        rerr = hresp_o;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [31:0] a, input logic [2:0] sz, input logic [31:0] exp);
        xfer(1'h0, a, sz, 4'h0, 32'h0);
        check(rdat, exp);
        check({31'h0, rerr}, 32'h0);
    endtask
    task automatic wr(input logic [31:0] a, input logic [2:0] sz, input logic [3:0] m,
                      input logic [31:0] wd, input logic eer);
        xfer(1'h1, a, sz, m, wd);
        check({31'h0, rerr}, {31'h0, eer});
    endtask
    task automatic pulse(input logic en);
        pm_gclk_enable_i <= en;
        pm_gclk_disable_i <= !en;
        @(posedge clk_i);
        pm_gclk_enable_i <= 1'h0;
        pm_gclk_disable_i <= 1'h0;
        @(posedge clk_i);
        check({31'h0, guard_clk_en_o}, {31'h0, en});
    endtask
    task final_report;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #160000;
        fail_count++;
        final_report();
    end
    initial
    begin
        // Clock runs from time zero, well before the first access
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        check({31'h0, guard_clk_en_o}, 32'h1);
        check({31'h0, gclk2}, 32'h0);
        check(prot2, 32'h0080_0000);
        rd(32'h0, 3'h2, 32'h2);
        rd(32'h4, 3'h2, 32'h2);
        $display("test reset done");
        pwait <= 4'h3;
        wr(32'h800, 3'h2, 4'h0, 32'hA5A5_1234, 1'h0);
        check({29'h0, pprot_o}, 32'h3);
        rd(32'h800, 3'h2, 32'hA5A5_1234);
        rd(32'h801, 3'h0, 32'h0000_1200);
        wr(32'h802, 3'h1, 4'h0, 32'h7777_0000, 1'h0);
        rd(32'h800, 3'h2, 32'h7777_1234);
        $display("test transfer done");
        pwait <= 4'h0;
        wr(32'h4, 3'h2, 4'h0, 32'h4, 1'h0);
        rd(32'h0, 3'h2, 32'h6);
        wr(32'h800, 3'h2, 4'h0, 32'hDEAD_0000, 1'h1);
        rd(32'h800, 3'h2, 32'h7777_1234);
        wr(32'h4, 3'h2, 4'h0, 32'h4, 1'h1);
        check(prot_state_o, 32'h6);
        wr(32'h800, 3'h2, 4'h1, 32'h0BAD_0000, 1'h0);
        rd(32'h800, 3'h2, 32'h0BAD_0000);
        wr(32'h0, 3'h2, 4'h0, 32'h0, 1'h0);
        rd(32'h4, 3'h2, 32'h6);
        wr(32'h0, 3'h2, 4'h0, 32'h4, 1'h0);
        check(prot_state_o, 32'h2);
        wr(32'h0, 3'h2, 4'h0, 32'h4, 1'h1);
        wr(32'h4, 3'h0, 4'h0, 32'h48, 1'h0);
        check(prot_state_o, 32'h4A);
        $display("test protection done");
        perr <= 1'h1;
        wr(32'h800, 3'h2, 4'h0, 32'h1, 1'h1);
        perr <= 1'h0;
        pulse(1'h0);
        rd(32'h0, 3'h2, 32'h0);
        wr(32'hC00, 3'h2, 4'h0, 32'h1, 1'h1);
        pulse(1'h1);
        rd(32'h4, 3'h2, 32'h4A);
        wr(32'h0, 3'h0, 4'h0, 32'h40, 1'h0);
        check(prot_state_o, 32'h0A);
        $display("test error and clock done");
        final_report();
    end
endmodule
`default_nettype wire
